// ===== ptd_far_model.sv
// far-side model: coordinator link status and temperature sensors
`timescale 1ns/1ps
module ptd_far_model
  import ptd_pkg::*;
(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                svc_req,
  input  wire logic                fire_req,
  input  wire ptd_pkg::ptd_temps_t temps_set,
  output ptd_pkg::ptd_temps_t      temps,
  output logic                     master_svc_active,
  output logic                     master_svc_firing
);
  // coordinator status arrives one clock late, like a real link
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      master_svc_active <= 1'b0;
      master_svc_firing <= 1'b0;
    end
    else
    begin
      master_svc_active <= svc_req;
      master_svc_firing <= fire_req;
    end

  // sensors report once a clock; cold sensors read zero in reset
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      temps <= '0;
    else
      temps <= temps_set;
endmodule : ptd_far_model

// ===== ptd_pkg.sv
// shared constants and types for the pump and tap demand controller
package ptd_pkg;
  // ****************************************************************
  // widths and limits
  // ****************************************************************
  localparam int TW = 12; // temperature word, signed
  localparam int CW = 20; // pump cycle counter width
  localparam int NPHYS = 3; // physical pump outputs
  localparam logic [CW-1:0] CYC_MAX = 20'hF423F; // 999999
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1_000_000_000; // one second timebase
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // ****************************************************************
  // register byte offsets and fields
  // ****************************************************************
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_SP = 12'h008;
  localparam logic [11:0] A_HYST = 12'h00C;
  localparam logic [11:0] A_RECOG = 12'h010;
  localparam logic [11:0] A_MINON = 12'h014;
  localparam logic [11:0] A_INSTOP = 12'h018;
  localparam logic [11:0] A_OUTSTOP = 12'h01C;
  localparam logic [11:0] A_RATE = 12'h020;
  localparam logic [11:0] A_WWSSP = 12'h024;
  localparam logic [11:0] A_BLKCFG = 12'h040;
  localparam logic [11:0] A_BLKCYC = 12'h060;
  localparam logic [11:0] A_PHYCYC = 12'h080;
  localparam int CTRL_UNITS = 0; // 1 = Fahrenheit
  localparam int CTRL_SLAVE = 1;
  localparam int CTRL_WWS = 2; // two bits
  localparam int CTRL_WWS_NONE = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;
  localparam int BC_SEL = 0; // 0 none, 1..3 output
  localparam int BC_MAN = 2;
  localparam int BC_DLY = 8;
  localparam int BC_OVR = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    WWS_EN = 2'h0, WWS_DIS = 2'h1, WWS_AFTER = 2'h2, WWS_NOW = 2'h3
  } ptd_wws_t;
  typedef enum logic [3:0] {
    PS_IDLE = 4'h1, PS_DLY = 4'h2, PS_RUN = 4'h4, PS_OVR = 4'h8
  } ptd_pst_t;
  typedef struct packed {
    logic [7:0] ovr;
    logic [7:0] dly;
    logic       manual;
    logic [1:0] sel;
  } ptd_blk_cfg_t;
  typedef struct packed {
    logic signed [TW-1:0] hw;
    logic signed [TW-1:0] inlet;
    logic signed [TW-1:0] outlet;
  } ptd_temps_t;
endpackage : ptd_pkg

// ===== ptd_tb.sv
// self-checking bench for the pump and tap demand controller
`timescale 1ns/1ps
module testbench;
  import ptd_pkg::*;
  typedef struct packed {
    logic [2:0]  blk;
    logic [31:0] cfg;
    logic [2:0]  exp;
  } ptd_row_t;
  localparam int T = 10; // short tick keeps the run brief
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tap_demand;
  logic firing, local_svc_active, svc_req, fire_req;
  logic master_svc_active, master_svc_firing;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pump_out;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [4:0]  pump_demand;
  ptd_temps_t  temps, temps_set;
  int errors, total_checks, n;
  ptd_row_t rows[8] = '{'{3'd0, 32'h5, 3'h1}, '{3'd1, 32'h6, 3'h3},
    '{3'd2, 32'h7, 3'h7}, '{3'd3, 32'h5, 3'h7}, '{3'd0, 32'h1, 3'h7},
    '{3'd3, 32'h4, 3'h6}, '{3'd1, 32'h0, 3'h4}, '{3'd2, 32'h3, 3'h0}};
  logic [31:0] ctl[4] = '{32'h01, 32'h04, 32'h19, 32'h1C};

  ptd_top #(.TICK_CYC(T)) ptd_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .temps(temps), .pump_demand(pump_demand), .firing(firing),
    .local_svc_active(local_svc_active),
    .master_svc_firing(master_svc_firing),
    .master_svc_active(master_svc_active), .pump_out(pump_out),
    .tap_demand(tap_demand));
  ptd_far_model ptd_far_model_i (.hclk(hclk), .hresetn(hresetn),
    .svc_req(svc_req), .fire_req(fire_req), .temps_set(temps_set),
    .temps(temps), .master_svc_active(master_svc_active),
    .master_svc_firing(master_svc_firing));

  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic finish_test;
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one single ahb transfer; values read just after an edge are sampled
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
    rv = hrdata;
    if (k >= 40)
    begin
      errors++;
      finish_test();
    end
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk("hrdata", rv, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : rd

  // bounded wait on pump output 0 or on tap demand
  task automatic wt(input bit tap, input logic v, input int lim);
    n = 0;
    while ((tap ? tap_demand : pump_out[0]) !== v && n < lim)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      finish_test();
    end
  endtask : wt

  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask : cyc

  task automatic st(input int h, input int i, input int o);
    temps_set <= '{TW'(h), TW'(i), TW'(o)};
  endtask : st

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {pump_demand, firing, local_svc_active, svc_req, fire_req} = '0;
    hsize = 3'h2;
    temps_set = '0;
    errors = 0;
    total_checks = 0;
    cyc(12);
    chk("rst", {pump_out, tap_demand, hreadyout}, 32'h1);
    hresetn <= 1'b1;
    cyc(1);
    rd(A_CTRL, 32'h1);
    foreach (ctl[i])
    begin
      wr(A_CTRL, ctl[i]);
      rd(A_CTRL, ctl[i]);
    end
    rd(12'h0FC, 32'h0);
    // routing and manual-on rows, cycles counted per output
    foreach (rows[i])
    begin
      wr(A_BLKCFG + 12'(4 * rows[i].blk), rows[i].cfg);
      cyc(4);
      chk("pump_out", 32'(pump_out), 32'(rows[i].exp));
    end
    for (int j = 0; j < 3; j++)
      rd(A_PHYCYC + 12'(4 * j), 32'h1);
    rd(A_BLKCYC + 12'h8, 32'h1);
    rd(A_BLKCYC + 12'h10, 32'h0);
    // start delay of 2 ticks: a short demand pulse never starts
    wr(A_BLKCFG, 32'h0201);
    pump_demand[0] <= 1'b1;
    cyc(5);
    pump_demand[0] <= 1'b0;
    cyc(40);
    chk("abort", 32'(pump_out[0]), 32'h0);
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 60);
    chk("delay", 32'(n >= 19 && n <= 34), 32'h1);
    wr(A_BLKCFG, 32'h30201);
    pump_demand[0] <= 1'b0;
    wt(0, 1'b0, 60);
    chk("overrun", 32'(n >= 28 && n <= 44), 32'h1);
    wr(A_BLKCFG, 32'h1);
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 6);
    pump_demand[0] <= 1'b0;
    wt(0, 1'b0, 6);
    // firing skips a long delay, locally or through the coordinator
    wr(A_BLKCFG, 32'h0501);
    firing <= 1'b1;
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 6);
    pump_demand[0] <= 1'b0;
    firing <= 1'b0;
    wt(0, 1'b0, 6);
    wr(A_CTRL, 32'h3);
    fire_req <= 1'b1;
    cyc(2);
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 6);
    {pump_demand[0], fire_req} <= 2'b00;
    wt(0, 1'b0, 6);
    firing <= 1'b1;
    pump_demand[0] <= 1'b1;
    cyc(20);
    chk("slave_local", 32'(pump_out[0]), 32'h0);
    {pump_demand[0], firing} <= 2'b00;
    cyc(4);
    // overrun cancelled by coordinator service, then by local service
    wr(A_BLKCFG, 32'h50001);
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 6);
    pump_demand[0] <= 1'b0;
    cyc(5);
    chk("ovr_on", 32'(pump_out[0]), 32'h1);
    svc_req <= 1'b1;
    wt(0, 1'b0, 6);
    svc_req <= 1'b0;
    wr(A_CTRL, 32'h1);
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 6);
    pump_demand[0] <= 1'b0;
    cyc(5);
    local_svc_active <= 1'b1;
    wt(0, 1'b0, 6);
    local_svc_active <= 1'b0;
    // counter write, saturation and clamp
    wr(A_BLKCFG, 32'h1);
    wr(A_PHYCYC, 32'hF423F);
    rd(A_PHYCYC, 32'hF423F);
    pump_demand[0] <= 1'b1;
    wt(0, 1'b1, 6);
    pump_demand[0] <= 1'b0;
    wt(0, 1'b0, 6);
    rd(A_PHYCYC, 32'hF423F);
    wr(A_PHYCYC, 32'hFFFFFF);
    rd(A_PHYCYC, 32'hF423F);
    wr(A_PHYCYC, 32'h0);
    rd(A_PHYCYC, 32'h0);
    // tap demand: setpoint 100, hysteresis 10, 2 s, min-on 1 s
    wr(A_SP, 32'd100);
    wr(A_HYST, 32'd10);
    wr(A_RECOG, 32'd2);
    wr(A_MINON, 32'd1);
    wr(A_INSTOP, 32'd5);
    wr(A_OUTSTOP, 32'd3);
    st(95, 95, 98);
    cyc(15);
    st(95, 95, 200);
    cyc(15);
    chk("tap_warm", 32'(tap_demand), 32'h0);
    st(90, 90, 200);
    wt(1, 1'b1, 40);
    chk("recog", 32'(n >= 19 && n <= 34), 32'h1);
    st(95, 99, 200);
    cyc(30);
    chk("tap_hold", 32'(tap_demand), 32'h1);
    st(95, 100, 200);
    wt(1, 1'b0, 14);
    st(90, 90, 200);
    wt(1, 1'b1, 40);
    st(95, 95, 99);
    cyc(30);
    chk("tap_out", 32'(tap_demand), 32'h1);
    st(95, 95, 98);
    wt(1, 1'b0, 14);
    // a fast fall far above the cold threshold still sets tap
    wr(A_RATE, 32'd20);
    st(150, 150, 300);
    cyc(30);
    st(120, 120, 300);
    wt(1, 1'b1, 25);
    finish_test();
  end

  // hang guard
  initial
  begin
    #600_000;
    errors++;
    finish_test();
  end
endmodule : testbench

// ===== ptd_top.sv
// pump function blocks, tap demand and ahb-lite register slave
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
// Contract
// - tap set after low temperature persists
// - clear when inlet minus hot water large
// - clear when outlet minus inlet small
// - hold Fahrenheit or Celsius unit setting
// - hold warm weather mode and setpoint
// - route each block to any output
// - shared output is OR of blocks
// - manual on holds pump on
// - start after delay if demand remains
// - zero start delay starts at once
// - standalone firing skips start delay
// - slave master firing skips start delay
// - overrun after demand, zero disables
// - standalone local service cancels overrun
// - slave master service cancels overrun
// - one counter per output, shared readback
// - counters span 0..999999, writable
// - tap set by temperature fall rate
module ptd_top
  import ptd_pkg::*;
#(
  parameter int N_BLK    = 5,
  parameter int TICK_CYC = ptd_pkg::TICK_CYC
)(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire ptd_pkg::ptd_temps_t temps,
  input  wire logic [N_BLK-1:0]   pump_demand,
  input  wire logic               firing,
  input  wire logic               local_svc_active,
  input  wire logic               master_svc_firing,
  input  wire logic               master_svc_active,
  output logic [2:0]              pump_out,
  output logic                    tap_demand
);
  import ptd_pkg::*;

  initial
  begin
    if (N_BLK < 1 || N_BLK > 8 || TICK_CYC < 1)
      $error("ptd_top: N_BLK must be 1..8, TICK_CYC at least 1");
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // configuration state
  // ****************************************************************
  logic [4:0]           ctrl_reg;
  logic signed [TW-1:0] sp_reg, hyst_reg, instop_reg, outstop_reg;
  logic signed [TW-1:0] rate_reg, wwssp_reg;
  logic [15:0]          recog_reg, minon_reg;
  ptd_blk_cfg_t         cfg_reg [N_BLK];
  logic [CW-1:0]        cyc_reg [NPHYS];
  logic                 slave;
  assign slave = ctrl_reg[CTRL_SLAVE];

  // ****************************************************************
  // bus slave: writes zero wait, reads one wait
  // ****************************************************************
  logic        dph_reg, dwr_reg;
  logic [11:0] da_reg;
  logic        wr_en;
  logic [11:0] wa;
  logic [2:0]  widx;
  assign wr_en = dph_reg & dwr_reg;
  assign wa = da_reg;
  assign widx = da_reg[4:2];

  // capture address phase; reads pull hreadyout low one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_reg <= 1'b0;
      dwr_reg <= 1'b0;
      da_reg <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0; // always OKAY
    end
    else
    begin
      dph_reg <= hsel & htrans[1] & hready;
      dwr_reg <= hwrite;
      if (hsel & htrans[1] & hready)
        da_reg <= haddr[11:0];
      hreadyout <= !(hsel & htrans[1] & hready & !hwrite);
    end
  end

  // configuration writes; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= CTRL_RST;
      sp_reg <= '0;
      hyst_reg <= '0;
      instop_reg <= '0;
      outstop_reg <= '0;
      rate_reg <= '0;
      wwssp_reg <= '0;
      recog_reg <= '0;
      minon_reg <= '0;
      for (int i = 0; i < N_BLK; i++)
        cfg_reg[i] <= '0;
    end
    else if (wr_en)
    begin
      if (wa == A_CTRL)
        ctrl_reg <= hwdata[4:0];
      else if (wa == A_SP)
        sp_reg <= hwdata[TW-1:0];
      else if (wa == A_HYST)
        hyst_reg <= hwdata[TW-1:0];
      else if (wa == A_RECOG)
        recog_reg <= hwdata[15:0];
      else if (wa == A_MINON)
        minon_reg <= hwdata[15:0];
      else if (wa == A_INSTOP)
        instop_reg <= hwdata[TW-1:0];
      else if (wa == A_OUTSTOP)
        outstop_reg <= hwdata[TW-1:0];
      else if (wa == A_RATE)
        rate_reg <= hwdata[TW-1:0];
      else if (wa == A_WWSSP)
        wwssp_reg <= hwdata[TW-1:0];
      else if (wa[11:5] == A_BLKCFG[11:5] && int'(widx) < N_BLK)
        cfg_reg[widx] <= {hwdata[BC_OVR+:8], hwdata[BC_DLY+:8],
                          hwdata[BC_MAN], hwdata[BC_SEL+:2]};
    end
  end

  // read mux from the captured address
  logic [31:0] rd_next;
  logic [1:0]  bsel;
  always_comb
  begin
    rd_next = 32'h0000_0000;
    bsel = cfg_reg[0].sel;
    if (int'(widx) < N_BLK)
      bsel = cfg_reg[widx].sel;
    if (da_reg == A_CTRL)
      rd_next = {27'h0, ctrl_reg};
    else if (da_reg == A_STAT)
      rd_next = {28'h0, pump_out, tap_demand};
    else if (da_reg == A_SP)
      rd_next = {{(32-TW){sp_reg[TW-1]}}, sp_reg};
    else if (da_reg == A_HYST)
      rd_next = {{(32-TW){hyst_reg[TW-1]}}, hyst_reg};
    else if (da_reg == A_RECOG)
      rd_next = {16'h0, recog_reg};
    else if (da_reg == A_MINON)
      rd_next = {16'h0, minon_reg};
    else if (da_reg == A_INSTOP)
      rd_next = {{(32-TW){instop_reg[TW-1]}}, instop_reg};
    else if (da_reg == A_OUTSTOP)
      rd_next = {{(32-TW){outstop_reg[TW-1]}}, outstop_reg};
    else if (da_reg == A_RATE)
      rd_next = {{(32-TW){rate_reg[TW-1]}}, rate_reg};
    else if (da_reg == A_WWSSP)
      rd_next = {{(32-TW){wwssp_reg[TW-1]}}, wwssp_reg};
    else if (da_reg[11:5] == A_BLKCFG[11:5] && int'(widx) < N_BLK)
      rd_next = {8'h0, cfg_reg[widx].ovr, cfg_reg[widx].dly, 5'h0,
                 cfg_reg[widx].manual, cfg_reg[widx].sel};
    else if (da_reg[11:5] == A_BLKCYC[11:5] && int'(widx) < N_BLK
             && bsel != 2'h0)
      rd_next = {12'h0, cyc_reg[bsel - 2'h1]};
    else if (da_reg[11:4] == A_PHYCYC[11:4] && da_reg[3:2] != 2'h3)
      rd_next = {12'h0, cyc_reg[da_reg[3:2]]};
  end

  // read data lands on the edge that returns hreadyout high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (dph_reg & !dwr_reg)
      hrdata <= rd_next;
  end

  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");

  // ****************************************************************
  // one second timebase
  // ****************************************************************
  logic [31:0] div_reg;
  logic        tick;
  assign tick = (div_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 32'h0;
    else
      div_reg <= tick ? 32'h0 : div_reg + 32'h1;
  end

  // ****************************************************************
  // tap demand
  // ****************************************************************
  logic signed [TW:0]   d_thr, d_in, d_out, d_fall;
  logic signed [TW-1:0] prev_reg;
  logic                 cold, set_lvl, set_rate, clr;
  logic [15:0]          rcg_reg, mon_reg;
  assign d_thr = 13'(sp_reg) - 13'(hyst_reg);
  assign cold = 13'(temps.hw) <= d_thr;
  assign d_in = 13'(temps.inlet) - 13'(temps.hw);
  assign d_out = 13'(temps.outlet) - 13'(temps.inlet);
  assign d_fall = 13'(prev_reg) - 13'(temps.hw);
  // only whole seconds count, so the set never comes a tick early
  assign set_lvl = cold && (recog_reg == 16'h0
                   || (tick && rcg_reg >= recog_reg));
  assign set_rate = tick && rate_reg > 0 && d_fall >= 13'(rate_reg);
  assign clr = (d_in > 0 && d_in >= 13'(instop_reg))
            || (d_out < 0 || d_out <= 13'(outstop_reg));

  // recognition time counts whole seconds of cold water
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rcg_reg <= 16'h0;
      prev_reg <= '0;
    end
    else
    begin
      if (!cold)
        rcg_reg <= 16'h0;
      else if (tick && rcg_reg != 16'hFFFF)
        rcg_reg <= rcg_reg + 16'h1;
      if (tick)
        prev_reg <= temps.hw;
    end
  end

  // set beats clear; clear only after the minimum on time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tap_demand <= 1'b0;
      mon_reg <= 16'h0;
    end
    else if (set_lvl || set_rate)
    begin
      tap_demand <= 1'b1;
      mon_reg <= minon_reg;
    end
    else
    begin
      if (tick && mon_reg != 16'h0)
        mon_reg <= mon_reg - 16'h1;
      if (clr && mon_reg == 16'h0)
        tap_demand <= 1'b0;
    end
  end

  a_tap_hold: assert property (tap_demand && mon_reg != 16'h0
    |=> tap_demand) else $error("tap dropped in minimum on");
  a_tap_clear: assert property (tap_demand && clr && mon_reg == 16'h0
    && !set_lvl && !set_rate |=> !tap_demand)
    else $error("tap clear missed");

  // ****************************************************************
  // pump function blocks
  // ****************************************************************
  logic [N_BLK-1:0] blk_on;
  logic             skip, cancel;
  assign skip = slave ? master_svc_firing : firing;
  assign cancel = slave ? master_svc_active : local_svc_active;

  for (genvar b = 0; b < N_BLK; b++)
  begin : g_blk
    ptd_pst_t   st_reg;
    logic [7:0] tmr_reg;
    logic       dem_q;
    logic       rise;
    assign rise = pump_demand[b] & !dem_q;
    assign blk_on[b] = cfg_reg[b].manual
                     | st_reg == PS_RUN | st_reg == PS_OVR;

    // start delay and overrun sequencing, counted in seconds
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        st_reg <= PS_IDLE;
        tmr_reg <= 8'h0;
        dem_q <= 1'b0;
      end
      else
      begin
        dem_q <= pump_demand[b];
        if (tick && tmr_reg != 8'h0)
          tmr_reg <= tmr_reg - 8'h1;
        case (st_reg)
          PS_IDLE:
            if (rise)
            begin
              if (cfg_reg[b].dly == 8'h0 || skip)
                st_reg <= PS_RUN;
              else
              begin
                st_reg <= PS_DLY;
                tmr_reg <= cfg_reg[b].dly;
              end
            end
          PS_DLY:
            if (!pump_demand[b])
              st_reg <= PS_IDLE;
            else if (tick && tmr_reg == 8'h0)
              st_reg <= PS_RUN;
          PS_RUN:
            if (!pump_demand[b])
            begin
              st_reg <= (cfg_reg[b].ovr == 8'h0) ? PS_IDLE : PS_OVR;
              tmr_reg <= cfg_reg[b].ovr;
            end
          PS_OVR:
            if (pump_demand[b])
              st_reg <= PS_RUN;
            else if (cancel || (tick && tmr_reg == 8'h0))
              st_reg <= PS_IDLE;
          default:
            st_reg <= PS_IDLE;
        endcase
      end
    end

    a_start_now: assert property (st_reg == PS_IDLE && rise
      && (cfg_reg[b].dly == 8'h0 || skip) |=> st_reg == PS_RUN)
      else $error("pump start not immediate");
    a_delay_drop: assert property (st_reg == PS_DLY && !pump_demand[b]
      |=> st_reg == PS_IDLE) else $error("delay kept without demand");
    a_ovr_cancel: assert property (st_reg == PS_OVR && cancel
      && !pump_demand[b] |=> st_reg == PS_IDLE)
      else $error("overrun not cancelled");
    a_ovr_zero: assert property (st_reg == PS_RUN && !pump_demand[b]
      && cfg_reg[b].ovr == 8'h0 |=> st_reg == PS_IDLE)
      else $error("zero overrun ran");
  end

  // ****************************************************************
  // physical outputs and cycle counters
  // ****************************************************************
  logic [2:0] or_next;
  always_comb
  begin
    or_next = 3'h0;
    for (int i = 0; i < N_BLK; i++)
      for (int j = 0; j < NPHYS; j++)
        if (cfg_reg[i].sel == 2'(j + 1) && blk_on[i])
          or_next[j] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pump_out <= 3'h0;
    else
      pump_out <= or_next;
  end

  // a bus write replaces the count even on a coincident rise
  for (genvar j = 0; j < NPHYS; j++)
  begin : g_cyc
    logic cwr;
    assign cwr = wr_en && wa == A_PHYCYC + 12'(4 * j);
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        cyc_reg[j] <= '0;
      else if (cwr)
        cyc_reg[j] <= (hwdata > 32'(CYC_MAX)) ? CYC_MAX
                                                 : hwdata[CW-1:0];
      else if (or_next[j] && !pump_out[j] && cyc_reg[j] != CYC_MAX)
        cyc_reg[j] <= cyc_reg[j] + 20'h1;
    end

    a_cyc_sat: assert property (cyc_reg[j] == CYC_MAX && !cwr
      |=> cyc_reg[j] == CYC_MAX) else $error("counter wrapped");
    a_cyc_incr: assert property (or_next[j] && !pump_out[j] && !cwr
      && cyc_reg[j] < CYC_MAX |=> cyc_reg[j] == $past(cyc_reg[j]) + 20'h1)
      else $error("counter missed a start");
  end
endmodule : ptd_top
